// ### list_sched_pkg.sv
// Package with register map, field positions and constants of the list schedule control block.
package list_sched_pkg;
  localparam logic [7:0]  HOST_CONTROL_OFFSET   = 8'h04;
  localparam logic [7:0]  COMMAND_STATUS_OFFSET = 8'h08;
  localparam logic [7:0]  IRQ_STATUS_OFFSET     = 8'h0c;
  localparam logic [7:0]  IRQ_CLEAR_OFFSET      = 8'h10;
  localparam logic [7:0]  IRQ_ENABLE_OFFSET     = 8'h14;
  localparam int          RATIO_LSB             = 0;
  localparam int          PERIODIC_BIT          = 2;
  localparam int          ISO_BIT               = 3;
  localparam int          CONTROL_BIT           = 4;
  localparam int          OVERRUN_COUNT_LSB     = 16;
  localparam int          OVERRUN_IRQ_BIT       = 0;
  localparam logic [31:0] HOST_CONTROL_MASK     = 32'h0000_001f;
  localparam logic [31:0] COMMAND_WRITE_MASK    = 32'h0000_000f;
  localparam logic [31:0] RESET_VALUE           = 32'h0000_0000;
  localparam logic [1:0]  RESP_OKAY             = 2'b00;
  localparam logic [1:0]  RESP_SLVERR           = 2'b10;
  typedef enum logic [1:0] {CONTROL_TURN, BULK_TURN} turn_t;
endpackage : list_sched_pkg

// ### list_schedule_control.sv
// List schedule control registers with AXI4-Lite slave and overrun interrupt.
`timescale 1ns/1ps
`default_nettype none
module list_schedule_control
  import list_sched_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        resetn,
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  input  wire logic        frameStart,
  input  wire logic        periodicPending,
  input  wire logic        isoDescriptorSeen,
  input  wire logic        nonperiodicDecide,
  input  wire logic        controlServed,
  input  wire logic        commandDone,
  input  wire logic [3:0]  commandDoneMask,
  output logic             controlListActive,
  output logic             periodicListActive,
  output logic             periodicContinue,
  output logic             serveControl,
  output logic             irq
);

  logic [31:0] hostControl;
  logic [31:0] commandStatus;
  logic [31:0] irqStatus;
  logic [31:0] irqEnable;
  logic [4:0]  frameEnables;
  logic [2:0]  servedCount;
  logic        overrun;
  logic [7:0]  wAddr;
  logic        wAddrHeld;
  logic [31:0] wData;
  logic [3:0]  wStrb;
  logic        wDataHeld;

  logic [31:0] next_hostControl;
  logic [31:0] next_commandStatus;
  logic [31:0] next_irqStatus;
  logic [31:0] next_irqEnable;
  logic [4:0]  next_frameEnables;
  logic [2:0]  next_servedCount;
  logic [7:0]  next_wAddr;
  logic        next_wAddrHeld;
  logic [31:0] next_wData;
  logic [3:0]  next_wStrb;
  logic        next_wDataHeld;
  logic        next_bvalid;
  logic        next_rvalid;
  logic [31:0] next_rdata;
  logic [1:0]  next_rresp;
  logic [1:0]  next_bresp;
  logic        doWrite;
  logic [31:0] strobed;

  function automatic logic [31:0] expand(input logic [3:0] s);
    expand = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
  endfunction : expand

  function automatic logic isMapped(input logic [7:0] a);
    isMapped = (a == HOST_CONTROL_OFFSET) || (a == COMMAND_STATUS_OFFSET) ||
               (a == IRQ_STATUS_OFFSET) || (a == IRQ_CLEAR_OFFSET) ||
               (a == IRQ_ENABLE_OFFSET);
  endfunction : isMapped

  assign awready = !wAddrHeld && !bvalid;
  assign wready  = !wDataHeld && !bvalid;
  assign arready = !rvalid;
  assign doWrite = wAddrHeld && wDataHeld && !bvalid;
  assign strobed = wData & expand(wStrb);

  // Frame latched copies keep mid-frame writes from touching the current schedule.
  assign controlListActive  = frameEnables[CONTROL_BIT];
  assign periodicListActive = frameEnables[PERIODIC_BIT];
  assign periodicContinue   = isoDescriptorSeen && frameEnables[ISO_BIT];
  // The count runs one past the ratio, so the bulk turn shows as serveControl low.
  assign serveControl = servedCount <= {1'b0, frameEnables[RATIO_LSB +: 2]};
  assign overrun = frameStart && periodicPending;
  assign irq = |(irqStatus & irqEnable);

  always_comb
  begin
    next_wAddr     = wAddr;
    next_wAddrHeld = wAddrHeld;
    next_wData     = wData;
    next_wStrb     = wStrb;
    next_wDataHeld = wDataHeld;
    next_bvalid    = bvalid && !bready;
    next_bresp     = bresp;
    next_rvalid    = rvalid && !rready;
    next_rdata     = rdata;
    next_rresp     = rresp;
    next_hostControl   = hostControl;
    next_commandStatus = commandStatus;
    next_irqStatus     = irqStatus;
    next_irqEnable     = irqEnable;
    next_frameEnables  = frameEnables;
    next_servedCount   = servedCount;
    if (awvalid && awready)
    begin
      next_wAddr     = awaddr;
      next_wAddrHeld = 1'b1;
    end
    if (wvalid && wready)
    begin
      next_wData     = wdata;
      next_wStrb     = wstrb;
      next_wDataHeld = 1'b1;
    end
    if (commandDone)
    begin
      next_commandStatus[3:0] = commandStatus[3:0] & ~commandDoneMask;
    end
    if (doWrite)
    begin
      next_wAddrHeld = 1'b0;
      next_wDataHeld = 1'b0;
      next_bvalid    = 1'b1;
      next_bresp     = isMapped(wAddr) ? RESP_OKAY : RESP_SLVERR;
      case (wAddr)
        HOST_CONTROL_OFFSET:
          next_hostControl = ((hostControl & ~expand(wStrb)) | strobed) & HOST_CONTROL_MASK;
        COMMAND_STATUS_OFFSET:
          next_commandStatus = next_commandStatus | (strobed & COMMAND_WRITE_MASK);
        IRQ_CLEAR_OFFSET:
          next_irqStatus = irqStatus & ~strobed;
        IRQ_ENABLE_OFFSET:
          next_irqEnable = strobed | (irqEnable & ~expand(wStrb));
        default:
          next_hostControl = hostControl;
      endcase
    end
    if (overrun)
    begin
      // The count moves even with the flag already set, so persistent trouble stays visible.
      next_commandStatus[OVERRUN_COUNT_LSB +: 2] =
        commandStatus[OVERRUN_COUNT_LSB +: 2] + 2'b01;
      next_irqStatus[OVERRUN_IRQ_BIT] = 1'b1;
    end
    if (frameStart)
    begin
      next_frameEnables = hostControl[4:0];
    end
    // Not cleared at frame start so the ratio carries over frames.
    if (nonperiodicDecide && controlServed && serveControl)
    begin
      next_servedCount = servedCount + 3'b001;
    end
    if (nonperiodicDecide && !controlServed && !serveControl)
    begin
      next_servedCount = 3'b000;
    end
    if (arvalid && arready)
    begin
      next_rvalid = 1'b1;
      next_rresp  = isMapped(araddr) ? RESP_OKAY : RESP_SLVERR;
      case (araddr)
        HOST_CONTROL_OFFSET:   next_rdata = hostControl;
        COMMAND_STATUS_OFFSET: next_rdata = commandStatus;
        IRQ_STATUS_OFFSET:     next_rdata = irqStatus;
        IRQ_ENABLE_OFFSET:     next_rdata = irqEnable;
        default:               next_rdata = RESET_VALUE;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      wAddr         <= 8'h00;
      wAddrHeld     <= 1'b0;
      wData         <= RESET_VALUE;
      wStrb         <= 4'h0;
      wDataHeld     <= 1'b0;
      bvalid        <= 1'b0;
      bresp         <= RESP_OKAY;
      rvalid        <= 1'b0;
      rdata         <= RESET_VALUE;
      rresp         <= RESP_OKAY;
      hostControl   <= RESET_VALUE;
      commandStatus <= RESET_VALUE;
      irqStatus     <= RESET_VALUE;
      irqEnable     <= RESET_VALUE;
      frameEnables  <= 5'h00;
      servedCount   <= 3'b000;
    end
    else
    begin
      wAddr         <= next_wAddr;
      wAddrHeld     <= next_wAddrHeld;
      wData         <= next_wData;
      wStrb         <= next_wStrb;
      wDataHeld     <= next_wDataHeld;
      bvalid        <= next_bvalid;
      bresp         <= next_bresp;
      rvalid        <= next_rvalid;
      rdata         <= next_rdata;
      rresp         <= next_rresp;
      hostControl   <= next_hostControl;
      commandStatus <= next_commandStatus;
      irqStatus     <= next_irqStatus;
      irqEnable     <= next_irqEnable;
      frameEnables  <= next_frameEnables;
      servedCount   <= next_servedCount;
    end
  end

  sequence s_overrunSeen;
    frameStart && periodicPending;
  endsequence

  property p_overrun_count;
    @(posedge mclk) disable iff (!resetn)
    s_overrunSeen |=> commandStatus[OVERRUN_COUNT_LSB +: 2] ==
      2'($past(commandStatus[OVERRUN_COUNT_LSB +: 2]) + 2'b01);
  endproperty
  a_overrun_count: assert property (p_overrun_count) else $error("overrun count not advanced");

  property p_overrun_flag;
    @(posedge mclk) disable iff (!resetn)
    s_overrunSeen |=> irqStatus[OVERRUN_IRQ_BIT];
  endproperty
  a_overrun_flag: assert property (p_overrun_flag) else $error("overrun flag not set");

  property p_wrap;
    @(posedge mclk) disable iff (!resetn)
    (s_overrunSeen ##0 (commandStatus[OVERRUN_COUNT_LSB +: 2] == 2'b11))
      |=> commandStatus[OVERRUN_COUNT_LSB +: 2] == 2'b00;
  endproperty
  a_wrap: assert property (p_wrap) else $error("overrun count did not wrap");

  property p_reserved;
    @(posedge mclk) disable iff (!resetn)
    commandStatus[31:24] == 8'h00;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bits not zero");

  property p_write_set;
    @(posedge mclk) disable iff (!resetn)
    (doWrite && wAddr == COMMAND_STATUS_OFFSET && !commandDone)
      |=> (commandStatus[3:0] & $past(commandStatus[3:0])) == $past(commandStatus[3:0]);
  endproperty
  a_write_set: assert property (p_write_set) else $error("command bit cleared by write");

  property p_hold_midframe;
    @(posedge mclk) disable iff (!resetn)
    !frameStart |=> $stable(frameEnables);
  endproperty
  a_hold_midframe: assert property (p_hold_midframe) else $error("enable changed mid frame");

  property p_control_latch;
    @(posedge mclk) disable iff (!resetn)
    frameStart |=> controlListActive == $past(hostControl[CONTROL_BIT]);
  endproperty
  a_control_latch: assert property (p_control_latch) else $error("control enable not latched");

  property p_periodic_latch;
    @(posedge mclk) disable iff (!resetn)
    frameStart |=> periodicListActive == $past(hostControl[PERIODIC_BIT]);
  endproperty
  a_periodic_latch: assert property (p_periodic_latch) else $error("periodic enable not latched");

  property p_iso;
    @(posedge mclk) disable iff (!resetn)
    (isoDescriptorSeen && !frameEnables[ISO_BIT]) |-> !periodicContinue;
  endproperty
  a_iso: assert property (p_iso) else $error("iso descriptor served while disabled");

  property p_count_kept;
    @(posedge mclk) disable iff (!resetn)
    (frameStart && !nonperiodicDecide) |=> $stable(servedCount);
  endproperty
  a_count_kept: assert property (p_count_kept) else $error("served count lost at frame");

  property p_ratio;
    @(posedge mclk) disable iff (!resetn)
    (nonperiodicDecide && controlServed && !frameStart &&
     servedCount == {1'b0, frameEnables[RATIO_LSB +: 2]}) |=> !serveControl;
  endproperty
  a_ratio: assert property (p_ratio) else $error("ratio exceeded");

endmodule : list_schedule_control
`default_nettype wire

// ### test_list_schedule_control.sv
// Self-checking testbench for the list schedule control registers.
`timescale 1ns/1ps
`default_nettype none
module test_list_schedule_control;
  import list_sched_pkg::*;
  logic        mclk, resetn, awvalid, wvalid, bready, arvalid, rready, awready, wready;
  logic        bvalid, arready, rvalid, frameStart, periodicPending, isoDescriptorSeen;
  logic        nonperiodicDecide, controlServed, commandDone, controlListActive;
  logic        periodicListActive, periodicContinue, serveControl, irq;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, a, b, c;
  logic [3:0]  wstrb, commandDoneMask;
  logic [1:0]  bresp, rresp;
  logic [33:0] note;
  logic [33:0] readQ[$];
  logic [1:0]  respQ[$];
  int          mismatches, tests_run, cycles, n;
  integer      seed;

  list_schedule_control u_list_schedule_control (.mclk, .resetn, .awaddr, .awvalid, .awready,
    .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready,
    .rdata, .rresp, .rvalid, .rready, .frameStart, .periodicPending, .isoDescriptorSeen,
    .nonperiodicDecide, .controlServed, .commandDone, .commandDoneMask, .controlListActive,
    .periodicListActive, .periodicContinue, .serveControl, .irq);

  always #10 mclk = ~mclk;

  task automatic close_out;
    $display("Checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : close_out

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp)
    begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // Handshakes are judged at the falling edge, where the inputs set at the last rising edge
  // and the slave's answer are settled, and take effect at the following rising edge.
  always @(negedge mclk)
  begin
    if (rvalid === 1'b1 && rready === 1'b1)
    begin
      note = readQ.pop_front();
      chk("rdata", note[31:0], rdata);
      chk("rresp", {30'h0, note[33:32]}, {30'h0, rresp});
    end
    if (bvalid === 1'b1 && bready === 1'b1)
      chk("bresp", {30'h0, respQ.pop_front()}, {30'h0, bresp});
  end

  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      mismatches++;
      close_out();
    end
  end

  task automatic wr(input logic [7:0] ad, input logic [31:0] d, input logic [1:0] resp);
    logic aw, w, bd;
    respQ.push_back(resp);
    @(posedge mclk);
    awaddr  <= ad;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    bd = 1'b0;
    while (!bd)
    begin
      @(negedge mclk);
      aw = awvalid & awready;
      w  = wvalid & wready;
      bd = bvalid & bready;
      @(posedge mclk);
      if (aw) awvalid <= 1'b0;
      if (w) wvalid <= 1'b0;
    end
    bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] ad, input logic [31:0] d, input logic [1:0] resp);
    logic ar, r;
    readQ.push_back({resp, d});
    @(posedge mclk);
    araddr  <= ad;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    r = 1'b0;
    while (!r)
    begin
      @(negedge mclk);
      ar = arvalid & arready;
      r  = rvalid & rready;
      @(posedge mclk);
      if (ar) arvalid <= 1'b0;
    end
    rready <= 1'b0;
  endtask : rd

  task automatic frame(input logic pend);
    @(posedge mclk);
    frameStart      <= 1'b1;
    periodicPending <= pend;
    @(posedge mclk);
    frameStart      <= 1'b0;
    periodicPending <= 1'b0;
    @(negedge mclk);
  endtask : frame

  task automatic decide(input logic served);
    @(posedge mclk);
    nonperiodicDecide <= 1'b1;
    controlServed     <= served;
    @(posedge mclk);
    nonperiodicDecide <= 1'b0;
    @(negedge mclk);
  endtask : decide

  initial
  begin
    {mclk, resetn, awvalid, wvalid, bready, arvalid, rready, frameStart} = '0;
    {periodicPending, isoDescriptorSeen, nonperiodicDecide, controlServed, commandDone} = '0;
    {awaddr, araddr, wdata, commandDoneMask} = '0;
    wstrb = 4'hf;
    seed  = 32'hc8102aca;
    repeat (4) @(posedge mclk);
    resetn <= 1'b1;
    rd(HOST_CONTROL_OFFSET, RESET_VALUE, RESP_OKAY);
    rd(COMMAND_STATUS_OFFSET, RESET_VALUE, RESP_OKAY);
    wr(HOST_CONTROL_OFFSET, 32'h0000_0014, RESP_OKAY);
    chk("controlListActive", 32'h0, {31'h0, controlListActive});
    frame(1'b0);
    chk("controlListActive", 32'h1, {31'h0, controlListActive});
    chk("periodicListActive", 32'h1, {31'h0, periodicListActive});
    @(posedge mclk);
    isoDescriptorSeen <= 1'b1;
    @(negedge mclk);
    chk("periodicContinue", 32'h0, {31'h0, periodicContinue});
    wr(HOST_CONTROL_OFFSET, 32'h0000_001c, RESP_OKAY);
    chk("periodicContinue", 32'h0, {31'h0, periodicContinue});
    frame(1'b0);
    chk("periodicContinue", 32'h1, {31'h0, periodicContinue});
    // Each ratio code must give code plus one control turns, then one bulk turn.
    for (int r = 0; r < 4; r++)
    begin
      wr(HOST_CONTROL_OFFSET, 32'h1c | r, RESP_OKAY);
      rd(HOST_CONTROL_OFFSET, 32'h1c | r, RESP_OKAY);
      frame(1'b0);
      n = 0;
      while (serveControl === 1'b1 && n < 8)
      begin
        n++;
        decide(1'b1);
        if (n == 1) frame(1'b0);
      end
      chk("controlTurns", r + 1, n);
      decide(1'b0);
      chk("serveControl", 32'h1, {31'h0, serveControl});
    end
    wr(HOST_CONTROL_OFFSET, RESET_VALUE, RESP_OKAY);
    frame(1'b0);
    chk("controlListActive", 32'h0, {31'h0, controlListActive});
    chk("periodicListActive", 32'h0, {31'h0, periodicListActive});
    wstrb <= 4'h0;
    wr(HOST_CONTROL_OFFSET, 32'h0000_001f, RESP_OKAY);
    wstrb <= 4'hf;
    rd(HOST_CONTROL_OFFSET, RESET_VALUE, RESP_OKAY);
    // The cursor sits outside this block, so re-enabling here never meets a stale one.
    wr(HOST_CONTROL_OFFSET, 32'h0000_0010, RESP_OKAY);
    chk("controlListActive", 32'h0, {31'h0, controlListActive});
    frame(1'b0);
    chk("controlListActive", 32'h1, {31'h0, controlListActive});
    a = $random(seed) & COMMAND_WRITE_MASK;
    b = $random(seed) & COMMAND_WRITE_MASK;
    wr(COMMAND_STATUS_OFFSET, a, RESP_OKAY);
    wr(COMMAND_STATUS_OFFSET, b, RESP_OKAY);
    rd(COMMAND_STATUS_OFFSET, a | b, RESP_OKAY);
    @(posedge mclk);
    commandDone     <= 1'b1;
    commandDoneMask <= a[3:0];
    @(posedge mclk);
    commandDone     <= 1'b0;
    c = (a | b) & ~a;
    rd(COMMAND_STATUS_OFFSET, c, RESP_OKAY);
    wr(IRQ_ENABLE_OFFSET, 32'h1, RESP_OKAY);
    for (int i = 1; i < 6; i++)
    begin
      frame(1'b1);
      chk("irq", 32'h1, {31'h0, irq});
      rd(COMMAND_STATUS_OFFSET, c | ((i & 3) << OVERRUN_COUNT_LSB), RESP_OKAY);
    end
    wr(IRQ_ENABLE_OFFSET, 32'h0, RESP_OKAY);
    chk("irq", 32'h0, {31'h0, irq});
    rd(IRQ_STATUS_OFFSET, 32'h1, RESP_OKAY);
    wr(IRQ_CLEAR_OFFSET, 32'h1, RESP_OKAY);
    rd(IRQ_STATUS_OFFSET, 32'h0, RESP_OKAY);
    rd(IRQ_CLEAR_OFFSET, 32'h0, RESP_OKAY);
    wr(IRQ_ENABLE_OFFSET, 32'h1, RESP_OKAY);
    chk("irq", 32'h0, {31'h0, irq});
    rd(8'h20, 32'h0, RESP_SLVERR);
    wr(8'h20, 32'h0, RESP_SLVERR);
    close_out();
  end
endmodule : test_list_schedule_control
`default_nettype wire
